//--- hdl/hop_flow_pkg.sv
// Operation
// - The hop-zero marker and ack flag act only while the status option is enabled.
// - When the radio hops to bin 0 the hop-zero marker is held low for that whole bin.
// - The marker falls on the hop frame falling edge starting bin 0 and rises on the next rise.
// - During every hop other than bin 0 the hop-zero marker stays high.
// - The status outputs are forced idle while line-emulation (modem) mode is selected.
// - The ack flag rests low and rises within 75 us of a valid RF acknowledgement.
// - A raised ack flag stays high until the rising hop frame edge ending the hop, then falls.
// - Clear-to-send is driven low while the device is ready to accept host serial data.
// - After going high, clear-to-send returns low once the buffer falls to the release level.
// - With host-hold enabled, a high request-to-send withholds serial output to the host.
// - Clear-to-send is driven high when the interface buffer is approaching full.
// - A high command-select input marks host bytes as data, a low one as commands.
package hop_flow_pkg;
   // Timing.
   localparam int CLK_PERIOD_NS    = 100;
   localparam int ACK_RISE_MAX_NS  = 75000;
   localparam int ACK_RISE_MAX_CYC = (ACK_RISE_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
                                     ACK_RISE_MAX_NS / CLK_PERIOD_NS;
   // Register byte offsets.
   localparam logic [7:0] ADDR_CTRL       = 8'h00;
   localparam logic [7:0] ADDR_CTS_ON     = 8'h04;
   localparam logic [7:0] ADDR_CTS_OFF    = 8'h08;
   localparam logic [7:0] ADDR_STATUS     = 8'h0c;
   localparam logic [7:0] ADDR_INT_STATUS = 8'h10;
   localparam logic [7:0] ADDR_INT_CLEAR  = 8'h14;
   localparam logic [7:0] ADDR_INT_ENABLE = 8'h18;
   // Control fields.
   localparam int CTRL_W          = 3;
   localparam int CTRL_STATUS_EN  = 0;
   localparam int CTRL_MODEM      = 1;
   localparam int CTRL_RTS_EN     = 2;
   localparam logic [2:0] CTRL_RST    = 3'h0;
   localparam logic [7:0] CTS_ON_RST  = 8'hc0;
   localparam logic [7:0] CTS_OFF_RST = 8'h40;
   // Status fields.
   localparam int STAT_LEVEL_LSB = 0;
   localparam int STAT_MARKER    = 8;
   localparam int STAT_ACK_FLAG  = 9;
   localparam int STAT_CTS       = 10;
   localparam int STAT_RTS       = 11;
   localparam int STAT_CMD_SEL   = 12;
   // Interrupt fields.
   localparam int INT_W    = 3;
   localparam int INT_ACK  = 0;
   localparam int INT_HOP0 = 1;
   localparam int INT_FULL = 2;
   localparam logic [2:0] INT_RST = 3'h0;

   typedef enum logic {cts_open, cts_held} cts_state_t;
endpackage : hop_flow_pkg

//--- hdl/hop_status_gen.sv
`timescale 1ns/1ps
module hop_status_gen (
   // Clock and reset.
   input  wire logic sys_clk,
   input  wire logic rst,
   // Radio core.
   input  wire logic feature_en,
   input  wire logic hop_frame,
   input  wire logic bin_zero,
   input  wire logic rf_ack_valid,
   // Outputs.
   output logic      hop_zero_marker,
   output logic      rf_ack_flag,
   output logic      hop0_start
);
   logic frame_q, frame_d;
   logic marker_q, marker_d;
   logic flag_q, flag_d;
   logic fall, rise;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      fall     = frame_q & ~hop_frame;
      rise     = ~frame_q & hop_frame;
      frame_d  = hop_frame;
      marker_d = marker_q;
      flag_d   = flag_q;
      if (!feature_en) begin
         marker_d = 1'b1;
         flag_d   = 1'b0;
      end else begin
         if (fall && bin_zero) begin
            marker_d = 1'b0;
         end else if (rise) begin
            marker_d = 1'b1;
         end
         // A new acknowledgement outranks the hop end so it is never lost.
         if (rf_ack_valid) begin
            flag_d = 1'b1;
         end else if (rise) begin
            flag_d = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         frame_q  <= 1'b0;
         marker_q <= 1'b1;
         flag_q   <= 1'b0;
      end else begin
         frame_q  <= frame_d;
         marker_q <= marker_d;
         flag_q   <= flag_d;
      end
   end

   assign hop_zero_marker = marker_q;
   assign rf_ack_flag     = flag_q;
   assign hop0_start      = feature_en & fall & bin_zero;

   ////////////////////////////////////////////////////////////////////////////
   marker_fall_a : assert property (
      @(posedge sys_clk) disable iff (rst)
      feature_en && frame_q && !hop_frame && bin_zero |=> !hop_zero_marker
   ) else $error("Marker did not fall at start of bin zero.");

   marker_cause_a : assert property (
      @(posedge sys_clk) disable iff (rst)
      $fell(hop_zero_marker) |-> $past(bin_zero) && $past(frame_q) && !$past(hop_frame)
   ) else $error("Marker fell outside a bin zero start.");

   marker_hold_a : assert property (
      @(posedge sys_clk) disable iff (rst)
      !hop_zero_marker && feature_en && !rise |=> !hop_zero_marker
   ) else $error("Marker rose before the bin ended.");

   flag_hold_a : assert property (
      @(posedge sys_clk) disable iff (rst)
      $fell(rf_ack_flag) |-> $past(rise) || !$past(feature_en)
   ) else $error("Ack flag fell without a hop end.");
endmodule : hop_status_gen

//--- hdl/cts_flow_ctrl.sv
`timescale 1ns/1ps
module cts_flow_ctrl (
   // Clock and reset.
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Levels.
   input  wire logic [7:0] buf_count,
   input  wire logic [7:0] on_level,
   input  wire logic [7:0] off_level,
   // Outputs.
   output logic            host_cts,
   output logic            full_event
);
   hop_flow_pkg::cts_state_t state_q, state_d;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         hop_flow_pkg::cts_open: begin
            if (buf_count >= on_level) begin
               state_d = hop_flow_pkg::cts_held;
            end
         end
         hop_flow_pkg::cts_held: begin
            if (buf_count <= off_level) begin
               state_d = hop_flow_pkg::cts_open;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= hop_flow_pkg::cts_open;
      end else begin
         state_q <= state_d;
      end
   end

   // Low means ready; the gap between the two levels keeps the line from chattering.
   assign host_cts   = (state_q == hop_flow_pkg::cts_held);
   assign full_event = (state_q == hop_flow_pkg::cts_open) &&
                       (state_d == hop_flow_pkg::cts_held);

   ////////////////////////////////////////////////////////////////////////////
   cts_raise_a : assert property (
      @(posedge sys_clk) disable iff (rst)
      !host_cts && buf_count >= on_level |=> host_cts
   ) else $error("CTS not raised at the high level.");

   cts_release_a : assert property (
      @(posedge sys_clk) disable iff (rst)
      host_cts && buf_count <= off_level |=> !host_cts
   ) else $error("CTS not released at the low level.");

   cts_stay_a : assert property (
      @(posedge sys_clk) disable iff (rst)
      !host_cts && buf_count < on_level |=> !host_cts
   ) else $error("CTS rose below the high level.");
endmodule : cts_flow_ctrl

//--- hdl/host_flow_status_signals.sv
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module host_flow_status_signals (
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // Wishbone slave.
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Radio core.
   input  wire logic        hop_frame,
   input  wire logic        bin_zero,
   input  wire logic        rf_ack_valid,
   input  wire logic [7:0]  buf_count,
   // Host handshake.
   input  wire logic        host_rts,
   input  wire logic        host_cmd_sel,
   output logic             host_cts,
   output logic             host_tx_hold,
   output logic             host_data_mode,
   // Status pins.
   output logic             hop_zero_marker,
   output logic             rf_ack_flag,
   // Interrupt.
   output logic             irq
);
   localparam int ack_bound = hop_flow_pkg::ACK_RISE_MAX_CYC;

   logic [hop_flow_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [7:0]                      cts_on_q, cts_on_d;
   logic [7:0]                      cts_off_q, cts_off_d;
   logic [hop_flow_pkg::INT_W-1:0]  int_stat_q, int_stat_d;
   logic [hop_flow_pkg::INT_W-1:0]  int_en_q, int_en_d;
   logic [hop_flow_pkg::INT_W-1:0]  int_set;
   logic [hop_flow_pkg::INT_W-1:0]  int_clr;
   logic                            ack_q, ack_d;
   logic [31:0]                     rdata_q, rdata_d;
   logic [31:0]                     status_word;
   logic                            wr_en;
   logic                            feature_en;
   logic                            rf_ack_edge;
   logic                            hop0_start;
   logic                            full_event;
   logic                            ack_flag_w;

   ////////////////////////////////////////////////////////////////////////////
   // The status pins are meaningless in modem mode, so that mode overrides the option.
   assign feature_en = ctrl_q[hop_flow_pkg::CTRL_STATUS_EN] &
                       ~ctrl_q[hop_flow_pkg::CTRL_MODEM];

   hop_status_gen u_hop (
      .sys_clk         (sys_clk),
      .rst             (rst),
      .feature_en      (feature_en),
      .hop_frame       (hop_frame),
      .bin_zero        (bin_zero),
      .rf_ack_valid    (rf_ack_valid),
      .hop_zero_marker (hop_zero_marker),
      .rf_ack_flag     (ack_flag_w),
      .hop0_start      (hop0_start)
   );
   assign rf_ack_flag = ack_flag_w;

   cts_flow_ctrl u_cts (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .buf_count  (buf_count),
      .on_level   (cts_on_q),
      .off_level  (cts_off_q),
      .host_cts   (host_cts),
      .full_event (full_event)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Host side of the serial link.
   assign host_tx_hold   = ctrl_q[hop_flow_pkg::CTRL_RTS_EN] & host_rts;
   assign host_data_mode = host_cmd_sel;

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave: every access is answered one cycle after it is seen, mapped or not.
   assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q & wb_sel_i[0];

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[hop_flow_pkg::STAT_LEVEL_LSB +: 8] = buf_count;
      status_word[hop_flow_pkg::STAT_MARKER]   = hop_zero_marker;
      status_word[hop_flow_pkg::STAT_ACK_FLAG] = ack_flag_w;
      status_word[hop_flow_pkg::STAT_CTS]      = host_cts;
      status_word[hop_flow_pkg::STAT_RTS]      = host_rts;
      status_word[hop_flow_pkg::STAT_CMD_SEL]  = host_cmd_sel;
   end

   always_comb begin
      ack_d     = wb_cyc_i & wb_stb_i & ~ack_q;
      rdata_d   = 32'h0000_0000;
      ctrl_d    = ctrl_q;
      cts_on_d  = cts_on_q;
      cts_off_d = cts_off_q;
      int_en_d  = int_en_q;
      int_clr   = '0;
      if (ack_d && !wb_we_i) begin
         unique case (wb_adr_i)
            hop_flow_pkg::ADDR_CTRL:       rdata_d[hop_flow_pkg::CTRL_W-1:0] = ctrl_q;
            hop_flow_pkg::ADDR_CTS_ON:     rdata_d[7:0] = cts_on_q;
            hop_flow_pkg::ADDR_CTS_OFF:    rdata_d[7:0] = cts_off_q;
            hop_flow_pkg::ADDR_STATUS:     rdata_d = status_word;
            hop_flow_pkg::ADDR_INT_STATUS: rdata_d[hop_flow_pkg::INT_W-1:0] = int_stat_q;
            hop_flow_pkg::ADDR_INT_ENABLE: rdata_d[hop_flow_pkg::INT_W-1:0] = int_en_q;
            default:                       rdata_d = 32'h0000_0000;
         endcase
      end
      if (wr_en) begin
         unique case (wb_adr_i)
            hop_flow_pkg::ADDR_CTRL:       ctrl_d = wb_dat_i[hop_flow_pkg::CTRL_W-1:0];
            hop_flow_pkg::ADDR_CTS_ON:     cts_on_d = wb_dat_i[7:0];
            hop_flow_pkg::ADDR_CTS_OFF:    cts_off_d = wb_dat_i[7:0];
            hop_flow_pkg::ADDR_INT_CLEAR:  int_clr = wb_dat_i[hop_flow_pkg::INT_W-1:0];
            hop_flow_pkg::ADDR_INT_ENABLE: int_en_d = wb_dat_i[hop_flow_pkg::INT_W-1:0];
            default:                       ctrl_d = ctrl_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status: a new event in the clearing cycle survives the clear.
   assign rf_ack_edge = feature_en & rf_ack_valid;

   always_comb begin
      int_set = '0;
      int_set[hop_flow_pkg::INT_ACK]  = rf_ack_edge;
      int_set[hop_flow_pkg::INT_HOP0] = hop0_start;
      int_set[hop_flow_pkg::INT_FULL] = full_event;
      int_stat_d = (int_stat_q & ~int_clr) | int_set;
   end

   assign irq = |(int_stat_q & int_en_q);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl_q     <= hop_flow_pkg::CTRL_RST;
         cts_on_q   <= hop_flow_pkg::CTS_ON_RST;
         cts_off_q  <= hop_flow_pkg::CTS_OFF_RST;
         int_stat_q <= hop_flow_pkg::INT_RST;
         int_en_q   <= hop_flow_pkg::INT_RST;
         ack_q      <= 1'b0;
         rdata_q    <= 32'h0000_0000;
      end else begin
         ctrl_q     <= ctrl_d;
         cts_on_q   <= cts_on_d;
         cts_off_q  <= cts_off_d;
         int_stat_q <= int_stat_d;
         int_en_q   <= int_en_d;
         ack_q      <= ack_d;
         rdata_q    <= rdata_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   ack_window_a : assert property (
      @(posedge sys_clk) disable iff (rst)
      feature_en && rf_ack_valid |-> ##[1:ack_bound] rf_ack_flag
   ) else $error("Ack flag late after a valid acknowledgement.");

   ack_rest_a : assert property (
      @(posedge sys_clk) disable iff (rst)
      $rose(rf_ack_flag) |-> $past(rf_ack_valid)
   ) else $error("Ack flag rose without an acknowledgement.");

   option_off_a : assert property (
      @(posedge sys_clk) disable iff (rst)
      !feature_en |=> hop_zero_marker && !rf_ack_flag
   ) else $error("Status pins active with the option off.");

   modem_block_a : assert property (
      @(posedge sys_clk) disable iff (rst)
      ctrl_q[hop_flow_pkg::CTRL_MODEM] |=> hop_zero_marker && !rf_ack_flag
   ) else $error("Status pins active in modem mode.");

   reset_idle_a : assert property (
      @(posedge sys_clk)
      $past(rst) && !rst |-> hop_zero_marker && !rf_ack_flag && !host_cts
   ) else $error("Outputs not idle after reset.");

   host_hold_a : assert property (
      @(posedge sys_clk) disable iff (rst)
      host_tx_hold == (host_rts && ctrl_q[hop_flow_pkg::CTRL_RTS_EN])
   ) else $error("Host hold does not follow request-to-send.");

   data_mode_a : assert property (
      @(posedge sys_clk) disable iff (rst)
      host_data_mode == host_cmd_sel
   ) else $error("Data mode does not follow command select.");

   bus_answer_a : assert property (
      @(posedge sys_clk) disable iff (rst)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o
   ) else $error("Bus answer not a single cycle after request.");

   set_wins_a : assert property (
      @(posedge sys_clk) disable iff (rst)
      int_set[hop_flow_pkg::INT_ACK] |=> int_stat_q[hop_flow_pkg::INT_ACK]
   ) else $error("Interrupt event lost.");

   irq_level_a : assert property (
      @(posedge sys_clk) disable iff (rst)
      (|(int_set & int_en_d)) |=> irq
   ) else $error("Enabled interrupt event did not raise the output.");
endmodule : host_flow_status_signals

//--- verif/host_model.sv
`timescale 1ns/1ps
// Behavioural host. It pushes one byte per cycle into the device buffer while
// allowed and a drain request empties it again. It honours clear-to-send even
// though a three-wire host could ignore it, since ignoring it only overruns.
module host_model (
   // Clock and reset.
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Bench control.
   input  wire logic       send_en,
   input  wire logic       drain,
   // Device side.
   input  wire logic       host_cts,
   output logic      [7:0] buf_count
);
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         buf_count <= 8'h00;
      end else if (drain && buf_count != 8'h00) begin
         buf_count <= buf_count - 8'h01;
      end else if (send_en && host_cts === 1'b0) begin
         buf_count <= buf_count + 8'h01;
      end
   end
endmodule : host_model

//--- verif/host_flow_status_signals_test.sv
`timescale 1ns/1ps
module host_flow_status_signals_test;
   logic        sys_clk, rst, cyc, stb, we, hop_frame, bin_zero, rf_ack_valid;
   logic        host_rts, host_cmd_sel, send_en, drain;
   logic [7:0]  adr;
   logic [31:0] dat, rd, wb_dat_o;
   logic [7:0]  buf_count;
   logic        wb_ack_o, host_cts, host_tx_hold, host_data_mode;
   logic        hop_zero_marker, rf_ack_flag, irq;
   int          n_errors, cmp_count, n;
   logic [7:0]  radr [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h18, 8'h1c};
   logic [31:0] rexp [6] = '{32'h0, 32'hc0, 32'h40, 32'h0, 32'h0, 32'h0};

   host_flow_status_signals u_host_flow_status_signals (.sys_clk(sys_clk), .rst(rst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .hop_frame(hop_frame),
      .bin_zero(bin_zero), .rf_ack_valid(rf_ack_valid), .buf_count(buf_count),
      .host_rts(host_rts), .host_cmd_sel(host_cmd_sel), .host_cts(host_cts),
      .host_tx_hold(host_tx_hold), .host_data_mode(host_data_mode),
      .hop_zero_marker(hop_zero_marker), .rf_ack_flag(rf_ack_flag), .irq(irq));
   host_model u_host_model (.sys_clk(sys_clk), .rst(rst), .send_en(send_en),
      .drain(drain), .host_cts(host_cts), .buf_count(buf_count));

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task end_of_test;
      if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // The request is held until ack is sampled high, then released.
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      // Only the watchdog ends a wait for the answer.
      do begin
         @(posedge sys_clk);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask : wb

   // One hop bin; the flags are looked at mid-bin and after the closing rise.
   task hop(input logic z, input logic a, input logic em, input logic ef);
      @(posedge sys_clk);
      hop_frame    <= 1'b0;
      bin_zero     <= z;
      rf_ack_valid <= a;
      @(posedge sys_clk);
      rf_ack_valid <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk(hop_zero_marker, em);
      chk(rf_ack_flag, ef);
      repeat (4) @(posedge sys_clk);
      hop_frame <= 1'b1;
      bin_zero  <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk(hop_zero_marker, 1'b1);
      chk(rf_ack_flag, 1'b0);
   endtask : hop

   // A hang is cut short well beyond the length of the sequence.
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      n_errors = 0;
      cmp_count = 0;
      {rst, cyc, stb, we, rf_ack_valid, host_rts, host_cmd_sel, send_en, drain} = '0;
      hop_frame = 1'b1;
      bin_zero = 1'b0;
      adr = 8'h00;
      dat = 32'h0;
      rst = 1'b1;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      chk({hop_zero_marker, rf_ack_flag, host_cts, irq}, 4'h8);
      for (int i = 0; i < 6; i++) begin
         wb(1'b0, radr[i], 32'h0);
         chk(rd, rexp[i]);
      end
      hop(1'b1, 1'b1, 1'b1, 1'b0);
      wb(1'b1, 8'h00, 32'h1);
      wb(1'b1, 8'h14, 32'h7);
      hop(1'b0, 1'b0, 1'b1, 1'b0);
      hop(1'b1, 1'b1, 1'b0, 1'b1);
      wb(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h3);
      chk(irq, 1'b0);
      wb(1'b1, 8'h18, 32'h1);
      chk(irq, 1'b1);
      wb(1'b1, 8'h14, 32'h1);
      chk(irq, 1'b0);
      wb(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h2);
      wb(1'b1, 8'h14, 32'h2);
      wb(1'b1, 8'h00, 32'h3);
      hop(1'b1, 1'b1, 1'b1, 1'b0);
      wb(1'b1, 8'h00, 32'h5);
      host_rts <= 1'b1;
      host_cmd_sel <= 1'b1;
      wb(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'h1900);
      chk({host_tx_hold, host_data_mode}, 2'h3);
      host_rts <= 1'b0;
      host_cmd_sel <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk({host_tx_hold, host_data_mode}, 2'h0);
      wb(1'b1, 8'h00, 32'h1);
      host_rts <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk(host_tx_hold, 1'b0);
      wb(1'b1, 8'h04, 32'h8);
      wb(1'b1, 8'h08, 32'h4);
      wb(1'b1, 8'h18, 32'h4);
      send_en <= 1'b1;
      n = 0;
      while (host_cts !== 1'b1 && n < 100) begin
         @(posedge sys_clk);
         n++;
      end
      @(posedge sys_clk);
      chk({host_cts, buf_count >= 8'h08, irq}, 3'h7);
      drain <= 1'b1;
      n = 0;
      while (host_cts !== 1'b0 && n < 100) begin
         @(posedge sys_clk);
         n++;
      end
      chk({host_cts, buf_count <= 8'h04}, 2'h1);
      end_of_test();
   end
endmodule : host_flow_status_signals_test
